// >>> logic/tpw_map.svh
// register offsets, field codes, reset values and timing counts
// Functional notes
// - prescaler select picks one of four clocks
// - count clock select zero counts operation clock
// - leader flag zero means slave channel
// - trigger source 111 uses leader up/down
// - third channel count mode 0100 one-count
// - low mode bit allows retrigger while counting
// - output enable gives pin to timer
// - output mode one means synchronous output
// - configuration one selects synchronous mode two
// - polarity bit inverts output when one
// - dead time enable inserts dead time
// - phase select picks delayed edge
// - rewrite enable holds data until trigger
// - source select picks leader or upper channel
// - rewrite on leader start at peak
// - interrupt monitor zero ignores upper channel interrupt
// - second channel mode 1001 up/down triangle
// - second channel at 0001 interrupts, resets output
`ifndef TPW_MAP_SVH
`define TPW_MAP_SVH
`define TPW_ADDR_W        4
`define TPW_OFS_MODE2     4'h0
`define TPW_OFS_MODE3     4'h1
`define TPW_OFS_OUTCTL    4'h2
`define TPW_OFS_RWCTL     4'h3
`define TPW_OFS_DATA2     4'h4
`define TPW_OFS_DATA3     4'h5
`define TPW_OFS_DTIME     4'h6
`define TPW_OFS_CNT2      4'h7
`define TPW_OFS_CNT3      4'h8
`define TPW_OFS_STATUS    4'h9
`define TPW_OFS_CTRL      4'hA
`define TPW_MODE_RST      16'h0000
`define TPW_OUTCTL_RST    16'h0000
`define TPW_RWCTL_RST     16'h0000
`define TPW_DATA_RST      16'h0000
`define TPW_DTIME_RST     16'h0000
`define TPW_CNT_PEAK_STOP 16'h0001
`define TPW_MD_UPDOWN     4'h9
`define TPW_MD_ONECOUNT   4'h4
`define TPW_STS_LEADER    3'h7
`define TPW_CNT_RELOAD_AT 16'h0000
`endif

// >>> logic/tpw_pkg.sv
// types shared by the slave pair
package tpw_pkg;
	typedef struct packed {
		logic [1:0] prescaler_select;        // 15:14
		logic [1:0] spare_hi;                // 13:12 (12 is count clock select)
		logic       leader_channel_flag;     // 11
		logic [2:0] start_trigger_source;    // 10:8
		logic [1:0] capture_overflow_field;  // 7:6
		logic [0:0] spare_lo;                // 5
		logic [3:0] count_mode_field;        // 4:1
		logic       low_mode_bit;            // 0
	} tpw_mode_t;
	// per-channel output control bits, six bits per slave
	typedef struct packed {
		logic output_enable_control;
		logic output_mode_bit;
		logic output_configuration_bit;
		logic output_polarity_bit;
		logic dead_time_enable;
		logic dead_time_phase_select;
	} tpw_outctl_t;
	typedef struct packed {
		logic rewrite_enable;
		logic rewrite_source_select;
		logic rewrite_interrupt_monitor;
	} tpw_rwctl_t;
	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} tpw_bus_t;
	typedef enum logic [0:0] {
		TPW_DIR_DOWN = 1'b0,
		TPW_DIR_UP   = 1'b1
	} tpw_dir_t;
endpackage

// >>> logic/tpw_dead_time.sv
// dead-time inserter for one complementary output
`timescale 1ns/100ps
`default_nettype none
module tpw_dead_time #(
	parameter int W = 16
) (
	input  wire logic         core_clk,
	input  wire logic         rstn,
	input  wire logic         tick,
	input  wire logic         enable,
	input  wire logic         phase_sel,
	input  wire logic [W-1:0] dead_cnt,
	input  wire logic         raw,
	output logic              shaped
);
	logic         prev_q;
	logic [W-1:0] cnt_q;
	logic         busy_q;
	logic         out_q;
	// edge that phase select chooses to delay: 0 rising, 1 falling
	wire delayed_edge = phase_sel ? (prev_q & ~raw) : (~prev_q & raw);
	wire start_dt = enable && delayed_edge && (dead_cnt != '0);
	wire dt_done = busy_q && tick && (cnt_q <= W'(1));
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			prev_q <= 1'b0;
			cnt_q  <= '0;
			busy_q <= 1'b0;
			out_q  <= 1'b0;
		end else begin
			prev_q <= raw;
			if (start_dt) begin
				busy_q <= 1'b1;
				cnt_q  <= dead_cnt;
			end else if (dt_done) begin
				busy_q <= 1'b0;
				out_q  <= raw;
			end else if (busy_q && tick) begin
				cnt_q <= cnt_q - W'(1);
			end else if (!busy_q) begin
				out_q <= raw;
			end
			if (busy_q && raw != prev_q) begin
				busy_q <= 1'b0;
				out_q  <= raw;
			end
		end
	end
	assign shaped = out_q;
	// a_dt_hold
	a_dt_hold: assert property (@(posedge core_clk) disable iff (!rstn)
		(start_dt && !busy_q) |=> busy_q && out_q == $past(out_q))
		else $error("dead time not held");
endmodule
`default_nettype wire

// >>> logic/tpw_slave_pair.sv
// two slave channels of a triangle pwm group with dead time
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "tpw_map.svh"
module tpw_slave_pair #(
	parameter int W = 16
) (
	input  wire logic              core_clk,
	input  wire logic              rstn,
	input  wire tpw_pkg::tpw_bus_t bus,
	output logic [15:0]            rdata,
	input  wire logic [3:0]        presc_tick,
	input  wire logic              leader_updown_trigger,
	input  wire logic              leader_start,
	input  wire logic              upper_rewrite_trigger,
	input  wire logic              upper_interrupt,
	input  wire logic [1:0]        sw_out_level,
	output logic [1:0]             channel_interrupt,
	output logic [1:0]             channel_output_pin
);
	import tpw_pkg::*;
	tpw_mode_t   mode2_q, mode3_q;
	tpw_outctl_t oc2_q, oc3_q;
	tpw_rwctl_t  rw_q;
	logic [W-1:0] data2_q, data3_q, buf2_q, buf3_q, dtime_q;
	logic [W-1:0] cnt2_q, cnt3_q;
	logic         run2_q, run3_q, dir2_q;
	logic         raw2_q, raw3_q;
	logic [1:0]   irq_q;
	logic [15:0]  rdata_q;
	logic [1:0]   shaped;
	logic         run_q;
	// tick of the selected prescaler output
	function automatic logic sel_tick(tpw_mode_t m, logic [3:0] t);
		// prescaler output pick; clock select zero
		sel_tick = t[m.prescaler_select] & ~m.spare_hi[0];
	endfunction
	function automatic logic started(tpw_mode_t m, logic trg);
		started = !m.leader_channel_flag &&
			m.start_trigger_source == `TPW_STS_LEADER && trg;
	endfunction
	wire tick2 = sel_tick(mode2_q, presc_tick);
	wire tick3 = sel_tick(mode3_q, presc_tick);
	wire trg2  = started(mode2_q, leader_updown_trigger);
	wire trg3s = started(mode3_q, leader_updown_trigger);
	wire updown2 = mode2_q.count_mode_field == `TPW_MD_UPDOWN;
	wire onecnt3 = mode3_q.count_mode_field == `TPW_MD_ONECOUNT;
	// peak-stop value on the triangle bottom
	wire hit2 = run2_q && tick2 && updown2 &&
		cnt2_q == W'(`TPW_CNT_PEAK_STOP) && !dir2_q;
	wire zero3 = run3_q && tick3 && cnt3_q == W'(`TPW_CNT_RELOAD_AT);
	// retrigger accepted only with low mode bit
	wire go3 = onecnt3 && (hit2 || trg3s) &&
		(!run3_q || mode3_q.low_mode_bit);
	// rewrite when leader starts while slave runs counting up
	wire at_peak = dir2_q && run2_q;
	wire rw_trig = rw_q.rewrite_source_select ?
		(upper_rewrite_trigger ||
		 (rw_q.rewrite_interrupt_monitor && upper_interrupt)) :
		(leader_start && at_peak);
	wire wr_hit2 = bus.wr && bus.addr == `TPW_OFS_DATA2;
	wire wr_hit3 = bus.wr && bus.addr == `TPW_OFS_DATA3;
	// register writes and buffered data
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mode2_q <= `TPW_MODE_RST;
			mode3_q <= `TPW_MODE_RST;
			oc2_q   <= '0;
			oc3_q   <= '0;
			rw_q    <= '0;
			dtime_q <= W'(`TPW_DTIME_RST);
			buf2_q  <= W'(`TPW_DATA_RST);
			buf3_q  <= W'(`TPW_DATA_RST);
			data2_q <= W'(`TPW_DATA_RST);
			data3_q <= W'(`TPW_DATA_RST);
		end else begin
			if (bus.wr) begin
				unique case (bus.addr)
					`TPW_OFS_MODE2: mode2_q <= bus.wdata;
					`TPW_OFS_MODE3: mode3_q <= bus.wdata;
					`TPW_OFS_OUTCTL: begin
						oc2_q <= bus.wdata[5:0];
						oc3_q <= bus.wdata[13:8];
					end
					`TPW_OFS_RWCTL: rw_q <= bus.wdata[2:0];
					`TPW_OFS_DTIME: dtime_q <= W'(bus.wdata);
					default: ;
				endcase
			end
			if (wr_hit2) buf2_q <= W'(bus.wdata);
			if (wr_hit3) buf3_q <= W'(bus.wdata);
			if (!rw_q.rewrite_enable) begin
				if (wr_hit2) data2_q <= W'(bus.wdata);
				if (wr_hit3) data3_q <= W'(bus.wdata);
			end else if (rw_trig) begin
				data2_q <= wr_hit2 ? W'(bus.wdata) : buf2_q;
				data3_q <= wr_hit3 ? W'(bus.wdata) : buf3_q;
			end
		end
	end
	// second channel triangle counter
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt2_q <= '0;
			run2_q <= 1'b0;
			dir2_q <= TPW_DIR_DOWN;
		end else if (trg2 && updown2) begin
			run2_q <= 1'b1;
			cnt2_q <= data2_q;
			dir2_q <= TPW_DIR_DOWN;
		end else if (run2_q && tick2) begin
			if (hit2) begin
				dir2_q <= TPW_DIR_UP;
				cnt2_q <= cnt2_q + W'(1);
			end else if (dir2_q) begin
				cnt2_q <= cnt2_q + W'(1);
			end else begin
				cnt2_q <= cnt2_q - W'(1);
			end
		end
	end
	// third channel one-count counter
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt3_q <= '0;
			run3_q <= 1'b0;
		end else if (go3) begin
			run3_q <= 1'b1;
			cnt3_q <= data3_q;
		end else if (zero3) begin
			run3_q <= 1'b0;
		end else if (run3_q && tick3) begin
			cnt3_q <= cnt3_q - W'(1);
		end
	end
	// synchronous set/reset; mode two; reset at hit
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			raw2_q <= 1'b0;
			raw3_q <= 1'b0;
			irq_q  <= 2'h0;
			run_q  <= 1'b0;
		end else begin
			irq_q <= {zero3, hit2};
			run_q <= run2_q | run3_q;
			if (oc2_q.output_mode_bit && oc2_q.output_configuration_bit) begin
				if (hit2) raw2_q <= 1'b0;
				else if (zero3) raw2_q <= 1'b1;
			end
			if (oc3_q.output_mode_bit && oc3_q.output_configuration_bit) begin
				if (hit2) raw3_q <= 1'b0;
				else if (zero3) raw3_q <= 1'b1;
			end
		end
	end
	tpw_dead_time #(.W(W)) u_dt2 (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.tick      (tick2),
		.enable    (oc2_q.dead_time_enable),
		.phase_sel (oc2_q.dead_time_phase_select),
		.dead_cnt  (dtime_q),
		.raw       (raw2_q),
		.shaped    (shaped[0])
	);
	tpw_dead_time #(.W(W)) u_dt3 (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.tick      (tick3),
		.enable    (oc3_q.dead_time_enable),
		.phase_sel (oc3_q.dead_time_phase_select),
		.dead_cnt  (dtime_q),
		.raw       (~raw3_q),
		.shaped    (shaped[1])
	);
	assign channel_output_pin[0] = oc2_q.output_enable_control ?
		(shaped[0] ^ oc2_q.output_polarity_bit) : sw_out_level[0];
	assign channel_output_pin[1] = oc3_q.output_enable_control ?
		(shaped[1] ^ oc3_q.output_polarity_bit) : sw_out_level[1];
	assign channel_interrupt = irq_q;
	// read mux, data one cycle later
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) rdata_q <= 16'h0000;
		else if (bus.rd) begin
			unique case (bus.addr)
				`TPW_OFS_MODE2:  rdata_q <= mode2_q;
				`TPW_OFS_MODE3:  rdata_q <= mode3_q;
				`TPW_OFS_OUTCTL: rdata_q <= {2'h0, oc3_q, 2'h0, oc2_q};
				`TPW_OFS_RWCTL:  rdata_q <= {13'h0000, rw_q};
				`TPW_OFS_DATA2:  rdata_q <= 16'(data2_q);
				`TPW_OFS_DATA3:  rdata_q <= 16'(data3_q);
				`TPW_OFS_DTIME:  rdata_q <= 16'(dtime_q);
				`TPW_OFS_CNT2:   rdata_q <= 16'(cnt2_q);
				`TPW_OFS_CNT3:   rdata_q <= 16'(cnt3_q);
				`TPW_OFS_STATUS: rdata_q <= {12'h000, run_q, dir2_q, run3_q, run2_q};
				default:         rdata_q <= 16'h0000;
			endcase
		end
	end
	assign rdata = rdata_q;
	// a_peak_irq
	a_peak_irq: assert property (@(posedge core_clk) disable iff (!rstn)
		hit2 |=> channel_interrupt[0]) else $error("no irq at 0001");
	// a_peak_turn
	a_peak_turn: assert property (@(posedge core_clk) disable iff (!rstn)
		hit2 |=> dir2_q) else $error("no turn at bottom");
	// a_oc_reset
	a_oc_reset: assert property (@(posedge core_clk) disable iff (!rstn)
		(hit2 && oc2_q.output_mode_bit && oc2_q.output_configuration_bit)
		|=> !raw2_q) else $error("output not reset");
	// a_pin_soft
	a_pin_soft: assert property (@(posedge core_clk) disable iff (!rstn)
		!oc2_q.output_enable_control |-> channel_output_pin[0] == sw_out_level[0])
		else $error("pin not software");
	// a_rw_hold
	a_rw_hold: assert property (@(posedge core_clk) disable iff (!rstn)
		(rw_q.rewrite_enable && !rw_trig) |=> $stable(data2_q))
		else $error("data changed early");
	// a_one_start
	a_one_start: assert property (@(posedge core_clk) disable iff (!rstn)
		(go3) |=> run3_q && cnt3_q == $past(data3_q)) else $error("no start");
	// a_retrig_block
	a_retrig_block: assert property (@(posedge core_clk) disable iff (!rstn)
		(run3_q && !mode3_q.low_mode_bit && !zero3 && tick3) |=>
		cnt3_q == $past(cnt3_q) - W'(1)) else $error("retrigger taken");
	// a_leader_trig
	a_leader_trig: assert property (@(posedge core_clk) disable iff (!rstn)
		(trg2 && updown2) |=> run2_q && !dir2_q) else $error("no slave start");
	// a_rw_peak
	a_rw_peak: assert property (@(posedge core_clk) disable iff (!rstn)
		(rw_q.rewrite_enable && !rw_q.rewrite_source_select &&
		 leader_start && at_peak && !wr_hit2) |=>
		data2_q == $past(buf2_q)) else $error("no rewrite at peak");
endmodule
`default_nettype wire

// >>> test/tpw_gate_model.sv
// gate driver stand-in that watches the two timer outputs
`timescale 1ns/100ps
`default_nettype none
module tpw_gate_model (
	input  wire logic       core_clk,
	input  wire logic       rstn,
	input  wire logic       hi_gate,
	input  wire logic       lo_gate,
	output logic [7:0]      hi_rise_cnt,
	output logic [7:0]      lo_rise_cnt
);
	logic hi_q;
	logic lo_q;
	// count switch-on events of both gates, saturating
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			hi_q        <= 1'b0;
			lo_q        <= 1'b0;
			hi_rise_cnt <= 8'h00;
			lo_rise_cnt <= 8'h00;
		end else begin
			hi_q <= hi_gate;
			lo_q <= lo_gate;
			if (hi_gate && !hi_q && hi_rise_cnt != 8'hFF) begin
				hi_rise_cnt <= hi_rise_cnt + 8'h01;
			end
			if (lo_gate && !lo_q && lo_rise_cnt != 8'hFF) begin
				lo_rise_cnt <= lo_rise_cnt + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// >>> test/test_tpw_slave_pair.sv
// self-checking testbench for the triangle pwm slave pair
`timescale 1ns/100ps
`default_nettype none
`include "tpw_map.svh"
module test_tpw_slave_pair;
	import tpw_pkg::*;
	logic        core_clk;
	logic        rstn;
	tpw_bus_t    bus;
	logic [15:0] rdata;
	logic [3:0]  presc_tick;
	logic        leader_updown_trigger;
	logic        leader_start;
	logic        upper_rewrite_trigger;
	logic        upper_interrupt;
	logic [1:0]  sw_out_level;
	logic [1:0]  channel_interrupt;
	logic [1:0]  channel_output_pin;
	logic [7:0]  hi_rise_cnt;
	logic [7:0]  lo_rise_cnt;
	logic [15:0] cnt_a;
	logic [15:0] cnt_b;
	int          error_cnt;
	int          total_checks;
	tpw_slave_pair u_dut (
		.core_clk              (core_clk),
		.rstn                  (rstn),
		.bus                   (bus),
		.rdata                 (rdata),
		.presc_tick            (presc_tick),
		.leader_updown_trigger (leader_updown_trigger),
		.leader_start          (leader_start),
		.upper_rewrite_trigger (upper_rewrite_trigger),
		.upper_interrupt       (upper_interrupt),
		.sw_out_level          (sw_out_level),
		.channel_interrupt     (channel_interrupt),
		.channel_output_pin    (channel_output_pin)
	);
	tpw_gate_model u_gate (
		.core_clk    (core_clk),
		.rstn        (rstn),
		.hi_gate     (channel_output_pin[0]),
		.lo_gate     (channel_output_pin[1]),
		.hi_rise_cnt (hi_rise_cnt),
		.lo_rise_cnt (lo_rise_cnt)
	);
	// 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] exp,
		input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus.wr <= 1'b0;
	endtask
	// read data stand from the cycle after the strobe until the next read
	task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
		@(posedge core_clk);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		bus.rd <= 1'b0;
		#1;
		v = rdata;
	endtask
	task automatic rd_chk(input string n, input logic [3:0] a,
		input logic [15:0] e);
		logic [15:0] v;
		rd_reg(a, v);
		chk(n, e, v);
	endtask
	task automatic pulse_trig();
		@(posedge core_clk);
		leader_updown_trigger <= 1'b1;
		@(posedge core_clk);
		leader_updown_trigger <= 1'b0;
	endtask
	// bounded wait for one interrupt pulse
	task automatic wait_irq(input int idx);
		int n;
		for (n = 0; n < 400; n++) begin
			@(posedge core_clk);
			#1;
			if (channel_interrupt[idx] === 1'b1) begin
				break;
			end
		end
		if (n == 400) begin
			chk("irq wait", 16'h0001, 16'h0000);
			results();
		end
	endtask
	// reset values, unmapped place and software pin control
	task automatic t_reset();
		chk("pins at reset", 16'h0002, {14'h0, channel_output_pin});
		chk("irq at reset", 16'h0000, {14'h0, channel_interrupt});
		rd_chk("mode2", `TPW_OFS_MODE2, `TPW_MODE_RST);
		rd_chk("mode3", `TPW_OFS_MODE3, `TPW_MODE_RST);
		rd_chk("outctl", `TPW_OFS_OUTCTL, `TPW_OUTCTL_RST);
		rd_chk("rwctl", `TPW_OFS_RWCTL, `TPW_RWCTL_RST);
		rd_chk("data2", `TPW_OFS_DATA2, `TPW_DATA_RST);
		rd_chk("dtime", `TPW_OFS_DTIME, `TPW_DTIME_RST);
		wr_reg(4'hF, 16'hA5A5);
		rd_chk("unmapped", 4'hF, 16'h0000);
		wr_reg(`TPW_OFS_OUTCTL, 16'h1818);
		sw_out_level <= 2'b01;
		@(posedge core_clk);
		#1;
		chk("sw pin", 16'h0001, {14'h0, channel_output_pin});
	endtask
	// counter must not move without its own enable
	task automatic t_stall(input string n, input logic [15:0] m,
		input logic [3:0] tick);
		presc_tick <= tick;
		wr_reg(`TPW_OFS_MODE2, m);
		wr_reg(`TPW_OFS_DATA2, 16'h0008);
		pulse_trig();
		rd_reg(`TPW_OFS_CNT2, cnt_a);
		repeat (20) @(posedge core_clk);
		rd_reg(`TPW_OFS_CNT2, cnt_b);
		chk(n, 16'h0008, cnt_a);
		chk(n, 16'h0008, cnt_b);
	endtask
	// full period with selected polarity
	task automatic t_run(input logic pol);
		presc_tick <= 4'b0100;
		// equal prescaler, capture field 00; no edge field
		wr_reg(`TPW_OFS_MODE2, 16'h8712);
		wr_reg(`TPW_OFS_MODE3, 16'h8709);
		wr_reg(`TPW_OFS_OUTCTL, pol ? 16'h3C3C : 16'h3838);
		wr_reg(`TPW_OFS_DATA2, 16'h0004);
		wr_reg(`TPW_OFS_DATA3, 16'h0010);
		rd_chk("mode2 back", `TPW_OFS_MODE2, 16'h8712);
		pulse_trig();
		wait_irq(0);
		repeat (2) @(posedge core_clk);
		#1;
		chk("ch2 pin", {15'h0, pol}, {15'h0, channel_output_pin[0]});
		chk("ch3 pin", {15'h0, ~pol}, {15'h0, channel_output_pin[1]});
		pulse_trig();
		wait_irq(1);
	endtask
	// held data, rewrite at leader peak and from upper channel
	task automatic t_rewrite();
		// leader assumed to carry the same rewrite settings
		wr_reg(`TPW_OFS_RWCTL, 16'h0004);
		wr_reg(`TPW_OFS_DATA2, 16'h0006);
		rd_chk("data2 held", `TPW_OFS_DATA2, 16'h0004);
		@(posedge core_clk);
		leader_start <= 1'b1;
		@(posedge core_clk);
		leader_start <= 1'b0;
		rd_chk("data2 peak", `TPW_OFS_DATA2, 16'h0006);
		wr_reg(`TPW_OFS_RWCTL, 16'h0006);
		wr_reg(`TPW_OFS_DATA2, 16'h0007);
		@(posedge core_clk);
		upper_interrupt <= 1'b1;
		@(posedge core_clk);
		upper_interrupt <= 1'b0;
		rd_chk("data2 no irq", `TPW_OFS_DATA2, 16'h0006);
		@(posedge core_clk);
		upper_rewrite_trigger <= 1'b1;
		@(posedge core_clk);
		upper_rewrite_trigger <= 1'b0;
		rd_chk("data2 upper", `TPW_OFS_DATA2, 16'h0007);
	endtask
	initial begin
		error_cnt = 0;
		total_checks = 0;
		rstn = 1'b0;
		bus = '{addr: 4'h0, wdata: 16'h0000, wr: 1'b0, rd: 1'b0};
		presc_tick = 4'b0000;
		leader_updown_trigger = 1'b0;
		leader_start = 1'b0;
		upper_rewrite_trigger = 1'b0;
		upper_interrupt = 1'b0;
		sw_out_level = 2'b10;
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		#1;
		t_reset();
		t_stall("ccs stop", 16'h9712, 4'b0100);
		t_stall("wrong tick", 16'h8712, 4'b1011);
		t_run(1'b0);
		t_run(1'b1);
		t_rewrite();
		chk("gate rises", 16'h0001, {15'h0, hi_rise_cnt != 8'h00});
		chk("lo rises", 16'h0001, {15'h0, lo_rise_cnt != 8'h00});
		results();
	end
endmodule
`default_nettype wire
